// ==== core/jddr_top.sv ====
// Debug data registers on the test port, with an AXI4-Lite processor side
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "jddr_regs.svh"
module jddr_top
(
   input  wire logic                 sys_clk,
   input  wire logic                 resetn,
   input  wire jddr_pkg::jddr_pins_t pins,
   input  wire jddr_pkg::jddr_core_t core,
   output logic                      tdo,
   output logic                      core_reset_n,
   output logic                      stop_issue,
   output logic                      enter_debug,
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready
);

   jddr_pkg::jddr_pins_t pin_meta;
   jddr_pkg::jddr_pins_t pin_sync;
   logic                 tck_q;
   logic                 tck_rise;
   logic                 tck_fall;
   logic                 sel_csr;
   logic                 sel_tx;
   logic                 sel_rx;
   logic                 cap;
   logic                 shf;
   logic                 upd;
   logic [35:0]          chain;
   logic [34:0]          holding;
   logic [31:0]          debug_ctrl_status_reg;
   logic [31:0]          tx_buf;
   logic [31:0]          rx_buf;
   logic                 tr;
   logic                 rr;
   logic                 ov;
   logic                 dl;
   logic                 hold_rst;
   logic                 brk_latch;
   logic                 tx_armed;
   logic                 defer;
   logic                 rx_write;
   logic [7:0]           aw_addr;
   logic                 aw_have;
   logic                 w_have;
   logic [31:0]          w_data;
   logic [3:0]           w_strb;
   logic                 wr_go;
   logic                 rx_rd;
   logic [31:0]          rd_word;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] val,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            res[8*i +: 8] = val[8*i +: 8];
      return res;
   endfunction

   function automatic logic mapped(input logic [7:0] addr);
      return addr == `JDDR_OFF_DEBUG_CTRL_STATUS_REG || addr == `JDDR_OFF_HS ||
             addr == `JDDR_OFF_TX || addr == `JDDR_OFF_RX ||
             addr == `JDDR_OFF_STAT;
   endfunction

   // Test port pins are asynchronous to sys_clk
   always_ff @(posedge sys_clk or negedge resetn)
      if (!resetn)
      begin
         pin_meta <= '0;
         pin_sync <= '0;
         tck_q    <= 1'b0;
      end
      else
      begin
         pin_meta <= pins;
         pin_sync <= pin_meta;
         tck_q    <= pin_sync.tck;
      end

   assign tck_rise = pin_sync.tck & ~tck_q;
   assign tck_fall = ~pin_sync.tck & tck_q;
   assign sel_csr  = pin_sync.instr == `JDDR_IR_CSR;
   assign sel_tx   = pin_sync.instr == `JDDR_IR_TX;
   assign sel_rx   = pin_sync.instr == `JDDR_IR_RX;
   assign cap      = tck_rise & pin_sync.capture_dr;
   assign shf      = tck_rise & pin_sync.shift_dr;
   assign upd      = tck_rise & pin_sync.update_dr;

   // One chain serves all three instructions
   always_ff @(posedge sys_clk or negedge resetn)
      if (!resetn)
         chain <= '0;
      else if (cap && sel_csr)
         chain <= {1'b0, debug_ctrl_status_reg, 1'b0, 1'b1, 1'b0};
      else if (cap && sel_tx)
         chain <= {1'b0, tx_buf, 2'b00, tr};
      else if (cap && sel_rx)
         chain <= {35'h0, rr};
      else if (shf && (sel_csr || sel_tx || sel_rx))
         chain <= {pin_sync.tdi, chain[35:1]};

   // Test data out changes on the falling test clock
   always_ff @(posedge sys_clk or negedge resetn)
      if (!resetn)
         tdo <= 1'b0;
      else if (tck_fall)
         tdo <= chain[0];

   // Holding register; transmit updates leave it alone
   always_ff @(posedge sys_clk or negedge resetn)
      if (!resetn)
         holding <= '0;
      else if (!pin_sync.trst_n)
      begin
         holding[`JDDR_HB_VALID] <= 1'b0;
         holding[1:0]            <= 2'b00;
      end
      else if (upd && sel_csr)
         holding <= {1'b0, chain[34:1]};
      else if (upd && sel_rx)
         holding <= chain[35:1];
      else if (rx_write)
         holding[`JDDR_HB_VALID] <= 1'b0;

   assign rx_write = holding[`JDDR_HB_VALID];

   // Control register: test port writes only its writable bits
   always_ff @(posedge sys_clk or negedge resetn)
      if (!resetn)
         debug_ctrl_status_reg <= `JDDR_DEBUG_CTRL_STATUS_REG_RST;
      else if (upd && sel_csr)
         debug_ctrl_status_reg <= (debug_ctrl_status_reg & ~`JDDR_DEBUG_CTRL_STATUS_REG_JMASK) |
                 (chain[34:3] & `JDDR_DEBUG_CTRL_STATUS_REG_JMASK);
      else if (wr_go && aw_addr == `JDDR_OFF_DEBUG_CTRL_STATUS_REG)
         debug_ctrl_status_reg <= merge(debug_ctrl_status_reg, w_data, w_strb);

   // Hold-in-reset follows chain bit 1 of each control update
   always_ff @(posedge sys_clk or negedge resetn)
      if (!resetn)
         hold_rst <= 1'b0;
      else if (!pin_sync.trst_n)
         hold_rst <= 1'b0;
      else if (upd && sel_csr)
         hold_rst <= chain[`JDDR_CH_HOLD];

   // Break stays latched until the core takes a debug exception
   always_ff @(posedge sys_clk or negedge resetn)
      if (!resetn)
         brk_latch <= 1'b0;
      else if (upd && sel_csr && chain[`JDDR_CH_BRK])
         brk_latch <= 1'b1;
      else if (core.debug_exc_taken)
         brk_latch <= 1'b0;

   // Halt mode defers in special state, monitor mode in abort
   assign defer = debug_ctrl_status_reg[`JDDR_DEBUG_CTRL_STATUS_REG_HALT] ? core.special_debug_state
                                        : core.abort_mode;

   always_ff @(posedge sys_clk or negedge resetn)
      if (!resetn)
      begin
         stop_issue   <= 1'b0;
         enter_debug  <= 1'b0;
         core_reset_n <= 1'b0;
      end
      else
      begin
         stop_issue   <= brk_latch & ~defer;
         enter_debug  <= stop_issue & brk_latch & core.idle;
         core_reset_n <= pin_sync.proc_reset_n & ~hold_rst;
      end

   // Transmit ready: a shift after a transmit capture reads it out
   always_ff @(posedge sys_clk or negedge resetn)
      if (!resetn)
         tx_armed <= 1'b0;
      else if (cap)
         tx_armed <= sel_tx;
      else if (shf || upd)
         tx_armed <= 1'b0;

   always_ff @(posedge sys_clk or negedge resetn)
      if (!resetn)
         tr <= 1'b0;
      else if (wr_go && aw_addr == `JDDR_OFF_TX)
         tr <= 1'b1;
      else if (shf && sel_tx && tx_armed)
         tr <= 1'b0;

   always_ff @(posedge sys_clk or negedge resetn)
      if (!resetn)
         tx_buf <= '0;
      else if (wr_go && aw_addr == `JDDR_OFF_TX)
         tx_buf <= merge(tx_buf, w_data, w_strb);

   // Receive write logic
   always_ff @(posedge sys_clk or negedge resetn)
      if (!resetn)
         rx_buf <= '0;
      else if (rx_write)
         rx_buf <= holding[33:2];

   always_ff @(posedge sys_clk or negedge resetn)
      if (!resetn)
         rr <= 1'b0;
      else if (rx_write)
         rr <= 1'b1;
      else if ((upd && sel_rx && chain[`JDDR_HB_FLUSH + 1]) || rx_rd)
         rr <= 1'b0;

   always_ff @(posedge sys_clk or negedge resetn)
      if (!resetn)
         ov <= 1'b0;
      else if (rx_write && rr)
         ov <= 1'b1;
      else if (wr_go && aw_addr == `JDDR_OFF_HS && w_strb[3] &&
               !w_data[`JDDR_HS_OV])
         ov <= 1'b0;

   always_ff @(posedge sys_clk or negedge resetn)
      if (!resetn)
         dl <= 1'b0;
      else if (upd && sel_rx)
         dl <= chain[`JDDR_HB_DL + 1];

   // AXI4-Lite write channel
   assign wr_go = aw_have & w_have & ~s_axi_bvalid;

   always_ff @(posedge sys_clk or negedge resetn)
      if (!resetn)
      begin
         aw_have       <= 1'b0;
         w_have        <= 1'b0;
         aw_addr       <= '0;
         w_data        <= '0;
         w_strb        <= '0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `JDDR_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         else if (wr_go)
            aw_have <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have       <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         else if (wr_go)
            w_have <= 1'b0;
         if (wr_go)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(aw_addr) ? `JDDR_RESP_OKAY
                                            : `JDDR_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end

   // AXI4-Lite read channel
   always_comb
   begin
      unique case (s_axi_araddr)
         `JDDR_OFF_DEBUG_CTRL_STATUS_REG: rd_word = debug_ctrl_status_reg;
         `JDDR_OFF_HS:   rd_word = {rr, ov, dl, tr, 28'h0};
         `JDDR_OFF_TX:   rd_word = tx_buf;
         `JDDR_OFF_RX:   rd_word = rx_buf;
         `JDDR_OFF_STAT: rd_word = {28'h0, enter_debug, stop_issue,
                                    brk_latch, hold_rst};
         default:        rd_word = 32'h0;
      endcase
   end

   assign rx_rd = s_axi_arvalid & s_axi_arready &
                  (s_axi_araddr == `JDDR_OFF_RX);

   always_ff @(posedge sys_clk or negedge resetn)
      if (!resetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= `JDDR_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_word;
         s_axi_rresp   <= mapped(s_axi_araddr) ? `JDDR_RESP_OKAY
                                               : `JDDR_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end

   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);

   csr_capture_a:
      assert property (cap && sel_csr |=> chain[34:3] == $past(debug_ctrl_status_reg)
                       && chain[1] && !chain[2])
         else $error("Control capture wrong");
   csr_update_a:
      assert property (upd && sel_csr && pin_sync.trst_n |=>
                       holding[33:2] == $past(chain[34:3]) &&
                       (debug_ctrl_status_reg & `JDDR_DEBUG_CTRL_STATUS_REG_JMASK) ==
                       ($past(chain[34:3]) & `JDDR_DEBUG_CTRL_STATUS_REG_JMASK))
         else $error("Control update wrong");
   hold_clear_a:
      assert property ($fell(hold_rst) |->
                       $past(!pin_sync.trst_n) ||
                       ($past(upd && sel_csr) && !$past(chain[1])))
         else $error("Hold cleared without zero update");
   core_reset_a:
      assert property (hold_rst |=> !core_reset_n)
         else $error("Core left reset while held");
   break_latch_a:
      assert property (upd && sel_csr && chain[2] |=> brk_latch [*2]
                       or ##1 core.debug_exc_taken)
         else $error("Break request not latched");
   break_defer_a:
      assert property (defer |=> !stop_issue)
         else $error("Break not deferred");
   debug_entry_a:
      assert property (enter_debug |-> $past(stop_issue) &&
                       $past(core.idle))
         else $error("Debug entered while busy");
   tx_capture_a:
      assert property (cap && sel_tx |=> chain[0] == $past(tr) &&
                       chain[34:3] == $past(tx_buf))
         else $error("Transmit capture wrong");
   tx_update_a:
      assert property (upd && sel_tx && pin_sync.trst_n |=>
                       $stable(holding) && $stable(hold_rst))
         else $error("Transmit update altered state");
   rx_write_a:
      assert property (rx_write |=> rr && !holding[34] &&
                       ov == ($past(rr) || $past(ov)))
         else $error("Receive write logic wrong");
   rx_payload_a:
      assert property (!rx_write |=> $stable(rx_buf))
         else $error("Receive buffer changed without valid");
   trst_clear_a:
      assert property (!pin_sync.trst_n |=> !holding[34] &&
                       holding[1:0] == 2'b00)
         else $error("Test reset did not clear holding");

endmodule

// ==== inc/jddr_regs.svh ====
// Offsets, bit positions, codes and reset values of the debug data registers
`ifndef JDDR_REGS_SVH
`define JDDR_REGS_SVH

`define JDDR_IR_CSR        5'h09
`define JDDR_IR_TX         5'h10
`define JDDR_IR_RX         5'h02

`define JDDR_OFF_DEBUG_CTRL_STATUS_REG      8'h00
`define JDDR_OFF_HS        8'h04
`define JDDR_OFF_TX        8'h08
`define JDDR_OFF_RX        8'h0C
`define JDDR_OFF_STAT      8'h10

`define JDDR_HS_RR         31
`define JDDR_HS_OV         30
`define JDDR_HS_DL         29
`define JDDR_HS_TR         28

`define JDDR_CH_BRK        2
`define JDDR_CH_HOLD       1
`define JDDR_HB_VALID      34
`define JDDR_HB_DL         1
`define JDDR_HB_FLUSH      0

`define JDDR_DEBUG_CTRL_STATUS_REG_HALT     30
`define JDDR_DEBUG_CTRL_STATUS_REG_JMASK    32'hC000_003F
`define JDDR_DEBUG_CTRL_STATUS_REG_RST      32'h0000_0000

`define JDDR_RESP_OKAY     2'h0
`define JDDR_RESP_SLVERR   2'h2

`endif

// ==== inc/jddr_pkg.sv ====
// Types shared by the debug data register block
package jddr_pkg;

   typedef struct packed {
      logic       tck;
      logic       trst_n;
      logic       tdi;
      logic       capture_dr;
      logic       shift_dr;
      logic       update_dr;
      logic [4:0] instr;
      logic       proc_reset_n;
   } jddr_pins_t;

   typedef struct packed {
      logic abort_mode;
      logic special_debug_state;
      logic idle;
      logic debug_exc_taken;
   } jddr_core_t;

endpackage

// ==== tb/jddr_host.sv ====
// Debugger model that drives the test port pins of the block
`timescale 1ns/10ps
module jddr_host
(
   input  wire logic            sys_clk,
   input  wire logic            tdo,
   output jddr_pkg::jddr_pins_t pins
);
   initial
   begin
      pins = '0;
      pins.proc_reset_n = 1'h1;
   end
   task automatic half(input logic lvl);
      pins.tck <= lvl;
      repeat (4) @(posedge sys_clk);
   endtask
   task automatic set_trst(input logic v);
      pins.trst_n <= v;
      repeat (6) @(posedge sys_clk);
   endtask
   task automatic set_prst(input logic v);
      pins.proc_reset_n <= v;
      repeat (6) @(posedge sys_clk);
   endtask
   // Capture, optional shift, update; tck rests low between scans
   task automatic scan(input logic [4:0] ir, input logic [35:0] din,
                       input int nsh, output logic [35:0] dout);
      dout = '0;
      pins.instr      <= ir;
      pins.capture_dr <= 1'h1;
      half(1'h0);
      half(1'h1);
      pins.capture_dr <= 1'h0;
      pins.shift_dr   <= (nsh != 0);
      pins.tdi        <= din[0];
      half(1'h0);
      for (int i = 0; i < nsh; i++)
      begin
         dout[i] = tdo;
         half(1'h1);
         pins.tdi <= din[(i + 1) % 36];
         half(1'h0);
      end
      pins.shift_dr  <= 1'h0;
      pins.update_dr <= 1'h1;
      half(1'h0);
      half(1'h1);
      pins.update_dr <= 1'h0;
      pins.tdi       <= ~pins.tdi;
      half(1'h0);
   endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the debug data registers
`timescale 1ns/10ps
`include "jddr_regs.svh"
`define CHK(g, e) \
   begin comparisons++; if ((g) !== (e)) begin err_total++; \
   $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
   typedef struct packed {
      logic [4:0]  ir;
      logic [35:0] din;
      logic [35:0] cap;
      logic [7:0]  ra;
      logic [31:0] rd;
   } jddr_row_t;
   logic                 sys_clk;
   logic                 resetn;
   jddr_pkg::jddr_pins_t pins;
   jddr_pkg::jddr_core_t core;
   logic                 tdo;
   logic                 core_reset_n;
   logic                 stop_issue;
   logic                 enter_debug;
   logic [7:0]           s_axi_awaddr;
   logic                 s_axi_awvalid;
   logic                 s_axi_awready;
   logic [31:0]          s_axi_wdata;
   logic [3:0]           s_axi_wstrb;
   logic                 s_axi_wvalid;
   logic                 s_axi_wready;
   logic [1:0]           s_axi_bresp;
   logic                 s_axi_bvalid;
   logic                 s_axi_bready;
   logic [7:0]           s_axi_araddr;
   logic                 s_axi_arvalid;
   logic                 s_axi_arready;
   logic [31:0]          s_axi_rdata;
   logic [1:0]           s_axi_rresp;
   logic                 s_axi_rvalid;
   logic                 s_axi_rready;
   int                   err_total;
   int                   comparisons;
   jddr_row_t            rows [8];
   logic [35:0]          dout;
   logic [34:0]          msk;
   logic [31:0]          d;
   logic [1:0]           r;
   jddr_host jddr_host_inst (.sys_clk, .tdo, .pins);
   jddr_top jddr_top_inst
   (
      .sys_clk, .resetn, .pins, .core, .tdo, .core_reset_n, .stop_issue,
      .enter_debug, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready
   );
   task automatic wr(input logic [7:0] a, input logic [31:0] v,
                     input logic [3:0] s, output logic [1:0] resp);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= v;
      s_axi_wstrb   <= s;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid  <= 1'h1;
      s_axi_bready  <= 1'h1;
      do
      begin
         @(posedge sys_clk);
         if (s_axi_awready && s_axi_awvalid)
            s_axi_awvalid <= 1'h0;
         if (s_axi_wready && s_axi_wvalid)
            s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      resp = s_axi_bresp;
      s_axi_bready <= 1'h0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v,
                     output logic [1:0] resp);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready  <= 1'h1;
      do
      begin
         @(posedge sys_clk);
         if (s_axi_arready && s_axi_arvalid)
            s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      v = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'h0;
      @(posedge sys_clk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] v;
      logic [1:0]  resp;
      rd(a, v, resp);
      `CHK(v, e)
      `CHK(resp, `JDDR_RESP_OKAY)
   endtask
   // Debug exception taken: drops the break latch
   task automatic exc();
      core.debug_exc_taken <= 1'h1;
      core.idle            <= 1'h0;
      @(posedge sys_clk);
      core.debug_exc_taken <= 1'h0;
      repeat (4) @(posedge sys_clk);
   endtask
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      sys_clk = 1'h0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   initial
   begin
      #1000000;
      err_total++;
      close_out();
   end
   initial
   begin
      err_total = 0;
      comparisons = 0;
      resetn = 1'h0;
      core = '0;
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
      rows[0] = '{`JDDR_IR_CSR, {1'h0, 32'h8000_0001, 3'h0},
                  {1'h0, 32'h1234_5678, 3'h2}, `JDDR_OFF_DEBUG_CTRL_STATUS_REG, 32'h9234_5641};
      rows[1] = '{`JDDR_IR_TX, 36'hF_FFFF_FFFF,
                  {1'h0, 32'hA5A5_5A5A, 3'h1}, `JDDR_OFF_HS, 32'h0};
      rows[2] = '{`JDDR_IR_TX, 36'h0,
                  {1'h0, 32'hA5A5_5A5A, 3'h0}, `JDDR_OFF_TX, 32'hA5A5_5A5A};
      rows[3] = '{`JDDR_IR_RX, {1'h1, 32'hCAFE_F00D, 3'h4},
                  36'h0, `JDDR_OFF_HS, 32'hA000_0000};
      rows[4] = '{`JDDR_IR_RX, {1'h1, 32'h1111_2222, 3'h4},
                  36'h1, `JDDR_OFF_RX, 32'h1111_2222};
      rows[5] = '{`JDDR_IR_RX, {1'h0, 32'hDEAD_BEEF, 3'h0},
                  36'h0, `JDDR_OFF_HS, 32'h4000_0000};
      rows[6] = '{`JDDR_IR_RX, {1'h0, 32'hDEAD_BEEF, 3'h0},
                  36'h0, `JDDR_OFF_RX, 32'h1111_2222};
      rows[7] = '{`JDDR_IR_CSR, {1'h0, 32'h9234_5641, 3'h4},
                  {1'h0, 32'h9234_5641, 3'h2}, `JDDR_OFF_STAT, 32'h6};
      repeat (20) @(posedge sys_clk);
      `CHK(core_reset_n, 1'h0)
      resetn <= 1'h1;
      jddr_host_inst.set_trst(1'h1);
      wr(`JDDR_OFF_TX, 32'hA5A5_5A5A, 4'hF, r);
      `CHK(r, `JDDR_RESP_OKAY)
      wr(`JDDR_OFF_DEBUG_CTRL_STATUS_REG, 32'h1234_5678, 4'hF, r);
      `CHK(r, `JDDR_RESP_OKAY)
      for (int i = 0; i < 8; i++)
      begin
         jddr_host_inst.scan(rows[i].ir, rows[i].din, 36, dout);
         msk = (rows[i].ir == `JDDR_IR_TX) ? 35'h7_FFFF_FFF9 : '1;
         `CHK(dout[34:0] & msk, rows[i].cap[34:0])
         rchk(rows[i].ra, rows[i].rd);
      end
      core.idle <= 1'h1;
      repeat (4) @(posedge sys_clk);
      `CHK(enter_debug, 1'h1)
      exc();
      rchk(`JDDR_OFF_STAT, 32'h0);
      // Monitor mode defers in abort, halt mode in the special state
      for (int m = 0; m < 2; m++)
      begin
         core.abort_mode          <= (m == 0);
         core.special_debug_state <= (m == 1);
         jddr_host_inst.scan(`JDDR_IR_CSR,
                             {2'h0, m[0], 30'h0, 3'h4}, 36, dout);
         `CHK(stop_issue, 1'h0)
         core.abort_mode          <= 1'h0;
         core.special_debug_state <= 1'h0;
         repeat (4) @(posedge sys_clk);
         `CHK(stop_issue, 1'h1)
         exc();
      end
      jddr_host_inst.set_prst(1'h0);
      jddr_host_inst.scan(`JDDR_IR_CSR, 36'h0, 0, dout);
      jddr_host_inst.set_prst(1'h1);
      `CHK(core_reset_n, 1'h0)
      rchk(`JDDR_OFF_STAT, 32'h1);
      rchk(`JDDR_OFF_DEBUG_CTRL_STATUS_REG, 32'h5234_5640);
      jddr_host_inst.scan(`JDDR_IR_CSR, 36'h0, 36, dout);
      repeat (4) @(posedge sys_clk);
      `CHK(core_reset_n, 1'h1)
      jddr_host_inst.scan(`JDDR_IR_CSR, 36'h0, 0, dout);
      repeat (4) @(posedge sys_clk);
      `CHK(core_reset_n, 1'h0)
      jddr_host_inst.set_trst(1'h0);
      `CHK(core_reset_n, 1'h1)
      jddr_host_inst.set_trst(1'h1);
      jddr_host_inst.scan(`JDDR_IR_RX, {1'h1, 32'h5555_AAAA, 3'h0}, 36, dout);
      jddr_host_inst.scan(`JDDR_IR_RX, 36'h2, 36, dout);
      `CHK(dout[0], 1'h1)
      rchk(`JDDR_OFF_HS, 32'h4000_0000);
      rchk(`JDDR_OFF_RX, 32'h5555_AAAA);
      wr(`JDDR_OFF_HS, 32'h0, 4'h8, r);
      rchk(`JDDR_OFF_HS, 32'h0);
      rd(8'h20, d, r);
      `CHK(r, `JDDR_RESP_SLVERR)
      `CHK(d, 32'h0)
      wr(8'h20, 32'hFFFF_FFFF, 4'hF, r);
      `CHK(r, `JDDR_RESP_SLVERR)
      close_out();
   end
endmodule
